// file: csb_map.vh
// register map, field positions and reset values of the chip-select b region block
// Notes on behaviour
// - with the region write-protect bit set, writes into the region are refused and give a bus error when bus errors are enabled.
// - with the supervisor-only bit set, user accesses to the protected sub-block are refused and give a bus error when bus errors are enabled.
// - with the protected-block write-protect bit set, any write to the protected sub-block is refused with a bus error.
// - the two-bit unprotected size field picks 32K, 64K, 128K or 256K bytes for the unprotected part.
// - with flash support clear, chip-select and write strobes fall on one edge; with it set, chip-select falls one clock earlier.
// - the bus-width bit picks an 8-bit data path when 0 and a 16-bit path when 1.
// - the wait field adds 0 to 12 wait states in steps of two plus the extra-wait bit; code 111 waits for the external acknowledge.
// - the three-bit size field gives a region size from 128K bytes up to 16 Mbyte.
// - the enable bit is write-only and chip-select is driven only while it holds 1.
`ifndef CSB_MAP_VH
`define CSB_MAP_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CSB_OFS_CONFIG    5'h00
`define CSB_OFS_CONTROL   5'h04
`define CSB_OFS_BASE      5'h08
`define CSB_OFS_STATUS    5'h0c
`define CSB_OFS_MASK      5'h10

// ****************************************
// configuration fields
// ****************************************
`define CSB_BIT_REGION_WP   15
`define CSB_BIT_SUPER_ONLY  14
`define CSB_BIT_PROT_WP     13
`define CSB_UNPROTECTED_BLOCK_SIZE_HI        12
`define CSB_UNPROTECTED_BLOCK_SIZE_LO        11
`define CSB_BIT_FLASH       8
`define CSB_BIT_WIDTH       7
`define CSB_WAIT_HI         6
`define CSB_WAIT_LO         4
`define CSB_SIZE_HI         3
`define CSB_SIZE_LO         1
`define CSB_BIT_ENABLE      0
// bits that exist in the register; reserved 10:9 are left out
`define CSB_CONFIG_WMASK    16'hf9ff
// enable is write-only and reads back as zero
`define CSB_CONFIG_RMASK    16'hf9fe

// ****************************************
// control, base, status fields
// ****************************************
`define CSB_BIT_BERR_EN     0
`define CSB_BIT_EXTRA_WAIT  1
`define CSB_BASE_HI         23
`define CSB_BASE_LO         17
`define CSB_EVT_REGION_WP   0
`define CSB_EVT_SUPER       1
`define CSB_EVT_PROT_WP     2

// ****************************************
// sizes and reset values
// ****************************************
`define CSB_REGION_SHIFT    5'd17
`define CSB_UNPROT_SHIFT    5'd15
`define CSB_WAIT_EXTERNAL   3'h7
`define CSB_RST_CONFIG      16'h0000
`define CSB_RST_CONTROL     2'h0
`define CSB_RST_BASE        7'h00
`define CSB_RST_EVENTS      3'h0

`endif

// file: csb_wait_gen.v
// wait-state counter for one strobe phase of the chip-select b region
`timescale 1ns/1ns

module csb_wait_gen
(
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // control
  input  wire       load_i,
  input  wire [2:0] wsel_i,
  input  wire       extra_i,
  input  wire       ext_ack_n_i,
  // result
  output wire       done_o
);

`include "csb_map.vh"

  reg [3:0] remain;
  reg       ext_mode;

  // ****************************************
  // count down
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remain   <= 4'h0;
      ext_mode <= 1'b0;
    end
    else if (load_i)
    begin
      remain   <= {wsel_i, 1'b0} + {3'h0, extra_i};
      ext_mode <= (wsel_i == `CSB_WAIT_EXTERNAL);
    end
    else if (remain != 4'h0)
    begin
      remain <= remain - 4'h1;
    end
  end

  assign done_o = ext_mode ? ~ext_ack_n_i : (remain == 4'h0);

endmodule

// file: csb_region.v
// chip-select b region: configuration registers, access checks and strobe timing
`timescale 1ns/1ns

module csb_region
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone register slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [4:2]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // processor access port
  input  wire        cpu_req_i,
  input  wire [23:0] cpu_addr_i,
  input  wire        cpu_we_i,
  input  wire        cpu_super_i,
  input  wire [1:0]  cpu_sel_i,
  input  wire [15:0] cpu_wdata_i,
  output reg  [15:0] cpu_rdata_o,
  output reg         cpu_ack_o,
  output reg         cpu_berr_o,
  // memory pins
  output reg         mem_cs_n_o,
  output reg         mem_oe_n_o,
  output reg         mem_lwe_n_o,
  output reg         mem_uwe_n_o,
  output reg  [23:0] mem_addr_o,
  output reg  [15:0] mem_dout_o,
  output reg         mem_doe_o,
  output reg         mem_wide_o,
  input  wire [15:0] mem_din_i,
  input  wire        mem_ext_ack_n_i,
  // interrupt
  output reg         irq_o
);

`include "csb_map.vh"

  localparam S_IDLE  = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_ACT   = 3'h2;
  localparam S_NEXT  = 3'h3;
  localparam S_FIN   = 3'h4;

  reg  [15:0] chip_select_b_config;
  reg         bus_error_enable;
  reg         extra_wait_bit;
  reg  [6:0]  region_base;
  reg  [2:0]  event_status;
  reg  [2:0]  event_mask;
  reg  [2:0]  state;
  reg         beat;
  reg  [2:0]  next_status;

  wire        region_write_protect;
  wire        protected_supervisor_only;
  wire        protected_block_write_protect;
  wire [1:0]  unprotected_block_size;
  wire        flash_support;
  wire        region_bus_width;
  wire [2:0]  wait_state_select;
  wire [2:0]  region_size_field;
  wire        region_enable;
  wire [23:0] region_mask;
  wire [23:0] region_offset;
  wire [23:0] unprot_limit_mask;
  wire        region_hit;
  wire        in_protected;
  wire        viol_region_wp;
  wire        viol_super;
  wire        viol_prot_wp;
  wire        any_viol;
  wire        raise_berr;
  wire        go;
  wire        flash_write;
  wire        two_beats;
  wire        cur_odd;
  wire        enter_act;
  wire        wait_done;
  wire        wb_hit;
  wire        wb_wr;
  wire        wb_rd;
  wire [15:0] wb_wdata;

  // ****************************************
  // configuration fields
  // ****************************************
  assign region_write_protect          = chip_select_b_config[`CSB_BIT_REGION_WP];
  assign protected_supervisor_only     = chip_select_b_config[`CSB_BIT_SUPER_ONLY];
  assign protected_block_write_protect = chip_select_b_config[`CSB_BIT_PROT_WP];
  assign unprotected_block_size        = chip_select_b_config[`CSB_UNPROTECTED_BLOCK_SIZE_HI:`CSB_UNPROTECTED_BLOCK_SIZE_LO];
  assign flash_support                 = chip_select_b_config[`CSB_BIT_FLASH];
  assign region_bus_width              = chip_select_b_config[`CSB_BIT_WIDTH];
  assign wait_state_select             = chip_select_b_config[`CSB_WAIT_HI:`CSB_WAIT_LO];
  assign region_size_field             = chip_select_b_config[`CSB_SIZE_HI:`CSB_SIZE_LO];
  assign region_enable                 = chip_select_b_config[`CSB_BIT_ENABLE];

  // ****************************************
  // address decode and checks
  // ****************************************
  // 128K shifted up by the size code
  assign region_mask   = 24'hffffff << (`CSB_REGION_SHIFT + {2'h0, region_size_field});
  assign region_offset = cpu_addr_i & ~region_mask;
  assign region_hit    = region_enable &&
                         (((cpu_addr_i ^ {region_base, 17'h00000}) & region_mask) == 24'h000000);
  // unprotected part is 32K shifted by the code
  assign unprot_limit_mask = 24'hffffff <<
                             (`CSB_UNPROT_SHIFT + {3'h0, unprotected_block_size});
  assign in_protected  = (region_offset & unprot_limit_mask) != 24'h000000;

  assign viol_region_wp = cpu_we_i && region_write_protect;
  assign viol_super     = in_protected && !cpu_super_i && protected_supervisor_only;
  assign viol_prot_wp   = in_protected && cpu_we_i && protected_block_write_protect;
  assign any_viol       = viol_region_wp || viol_super || viol_prot_wp;
  assign raise_berr     = ((viol_region_wp || viol_super) && bus_error_enable) || viol_prot_wp;

  assign go          = (state == S_IDLE) && cpu_req_i && region_hit && !any_viol;
  assign flash_write = flash_support && cpu_we_i;
  // a word on the 8-bit path takes two beats
  assign two_beats   = !region_bus_width && (cpu_sel_i == 2'h3);
  assign cur_odd     = two_beats ? beat : !cpu_sel_i[1];
  assign enter_act   = (((state == S_IDLE) && go) || (state == S_NEXT)) && !flash_write ||
                       (state == S_SETUP);

  csb_wait_gen u_wait
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .load_i      (enter_act),
    .wsel_i      (wait_state_select),
    .extra_i     (extra_wait_bit),
    .ext_ack_n_i (mem_ext_ack_n_i),
    .done_o      (wait_done)
  );

  // ****************************************
  // access sequencer
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state       <= S_IDLE;
      beat        <= 1'b0;
      mem_cs_n_o  <= 1'b1;
      mem_oe_n_o  <= 1'b1;
      mem_lwe_n_o <= 1'b1;
      mem_uwe_n_o <= 1'b1;
      mem_addr_o  <= 24'h000000;
      mem_dout_o  <= 16'h0000;
      mem_doe_o   <= 1'b0;
      cpu_rdata_o <= 16'h0000;
      cpu_ack_o   <= 1'b0;
      cpu_berr_o  <= 1'b0;
    end
    else
    begin
      cpu_ack_o  <= 1'b0;
      cpu_berr_o <= 1'b0;
      case (state)
        S_IDLE:
        begin
          beat <= 1'b0;
          if (cpu_req_i && region_hit && any_viol)
          begin
            // refused access: no memory cycle, writes dropped
            cpu_berr_o <= raise_berr;
            cpu_ack_o  <= !raise_berr;
            state      <= S_FIN;
          end
          else if (go)
          begin
            state <= flash_write ? S_SETUP : S_ACT;
          end
        end
        S_SETUP: state <= S_ACT;
        S_ACT:
        begin
          if (wait_done)
          begin
            mem_cs_n_o  <= 1'b1;
            mem_oe_n_o  <= 1'b1;
            mem_lwe_n_o <= 1'b1;
            mem_uwe_n_o <= 1'b1;
            mem_doe_o   <= 1'b0;
            if (!cpu_we_i)
            begin
              if (region_bus_width)
                cpu_rdata_o <= mem_din_i;
              else if (cur_odd)
                cpu_rdata_o[7:0] <= mem_din_i[7:0];
              else
                cpu_rdata_o[15:8] <= mem_din_i[7:0];
            end
            if (two_beats && !beat)
            begin
              beat  <= 1'b1;
              state <= S_NEXT;
            end
            else
            begin
              cpu_ack_o <= 1'b1;
              state     <= S_FIN;
            end
          end
        end
        S_NEXT:  state <= flash_write ? S_SETUP : S_ACT;
        S_FIN:   state <= S_IDLE;
        default: state <= S_IDLE;
      endcase

      // pin drive at the start of each beat
      if (go || (state == S_NEXT))
      begin
        // chip-select only for an enabled region
        mem_cs_n_o <= 1'b0;
        mem_doe_o  <= cpu_we_i;
        mem_addr_o <= region_bus_width ? {cpu_addr_i[23:1], 1'b0}
                                       : {cpu_addr_i[23:1], cur_odd};
        if (region_bus_width)
          mem_dout_o <= cpu_wdata_i;
        else
          mem_dout_o <= {8'h00, cur_odd ? cpu_wdata_i[7:0] : cpu_wdata_i[15:8]};
      end
      // strobes with chip-select, or one clock after it
      if (enter_act)
      begin
        mem_oe_n_o  <= cpu_we_i;
        mem_lwe_n_o <= !(cpu_we_i && (region_bus_width ? cpu_sel_i[0] : 1'b1));
        mem_uwe_n_o <= !(cpu_we_i && region_bus_width && cpu_sel_i[1]);
      end
    end
  end

  // ****************************************
  // wishbone register slave
  // ****************************************
  assign wb_hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr    = wb_hit && wb_we_i;
  assign wb_rd    = wb_hit && !wb_we_i;
  assign wb_wdata = {wb_sel_i[1] ? wb_dat_i[15:8] : chip_select_b_config[15:8],
                     wb_sel_i[0] ? wb_dat_i[7:0]  : chip_select_b_config[7:0]};

  // event capture: a new event wins over the read clear
  always @*
  begin
    next_status = event_status;
    if (wb_rd && ({wb_adr_i, 2'h0} == `CSB_OFS_STATUS))
      next_status = `CSB_RST_EVENTS;
    if ((state == S_IDLE) && cpu_req_i && region_hit)
      next_status = next_status | {viol_prot_wp, viol_super, viol_region_wp};
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chip_select_b_config <= `CSB_RST_CONFIG;
      bus_error_enable     <= 1'b0;
      extra_wait_bit       <= 1'b0;
      region_base          <= `CSB_RST_BASE;
      event_status         <= `CSB_RST_EVENTS;
      event_mask           <= `CSB_RST_EVENTS;
      wb_ack_o             <= 1'b0;
      wb_dat_o             <= 32'h00000000;
      irq_o                <= 1'b0;
      mem_wide_o           <= 1'b0;
    end
    else
    begin
      wb_ack_o     <= wb_hit;
      event_status <= next_status;
      irq_o        <= |(next_status & event_mask);
      mem_wide_o   <= region_bus_width;
      if (wb_wr)
      begin
        case ({wb_adr_i, 2'h0})
          `CSB_OFS_CONFIG:
          begin
            chip_select_b_config <= wb_wdata & `CSB_CONFIG_WMASK;
          end
          `CSB_OFS_CONTROL:
          begin
            if (wb_sel_i[0])
            begin
              bus_error_enable <= wb_dat_i[`CSB_BIT_BERR_EN];
              extra_wait_bit   <= wb_dat_i[`CSB_BIT_EXTRA_WAIT];
            end
          end
          `CSB_OFS_BASE:
          begin
            if (wb_sel_i[2] && wb_sel_i[1])
              region_base <= wb_dat_i[`CSB_BASE_HI:`CSB_BASE_LO];
          end
          `CSB_OFS_MASK:
          begin
            if (wb_sel_i[0])
              event_mask <= wb_dat_i[2:0];
          end
          default:
          begin
            chip_select_b_config <= chip_select_b_config;
          end
        endcase
      end
      wb_dat_o <= 32'h00000000;
      if (wb_rd)
      begin
        case ({wb_adr_i, 2'h0})
          `CSB_OFS_CONFIG:  wb_dat_o <= {16'h0000, chip_select_b_config & `CSB_CONFIG_RMASK};
          `CSB_OFS_CONTROL: wb_dat_o <= {30'h00000000, extra_wait_bit, bus_error_enable};
          `CSB_OFS_BASE:    wb_dat_o <= {8'h00, region_base, 17'h00000};
          `CSB_OFS_STATUS:  wb_dat_o <= {29'h00000000, event_status};
          `CSB_OFS_MASK:    wb_dat_o <= {29'h00000000, event_mask};
          default:          wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// file: csb_region_monitor.sv
// assertion checker of the chip-select b region block
`timescale 1ns/1ns

module csb_region_monitor
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // processor port
  input wire cpu_req_i,
  input wire cpu_ack_o,
  input wire cpu_berr_o,
  // memory pins and interrupt
  input wire mem_cs_n_o,
  input wire mem_oe_n_o,
  input wire mem_doe_o,
  input wire mem_lwe_n_o,
  input wire mem_uwe_n_o,
  input wire mem_wide_o,
  input wire irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // properties
  // ****
  AST_WB_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register request not answered");
  AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack longer than one cycle");
  AST_RESET_QUIET: assert property (disable iff (1'b0) rst_i |=> mem_cs_n_o && !irq_o
    && !cpu_ack_o && !cpu_berr_o && !wb_ack_o)
    else $error("outputs active after reset");
  AST_STROBE_IN_CS: assert property (!mem_lwe_n_o || !mem_uwe_n_o |-> !mem_cs_n_o)
    else $error("write strobe outside chip-select");
  // strobe may fall with or after chip-select, never before
  AST_FLASH_ORDER: assert property ($fell(mem_lwe_n_o) |-> !$past(mem_cs_n_o) || $fell(mem_cs_n_o))
    else $error("write strobe ahead of chip-select");
  // data driven only inside a selected write, never against the memory
  AST_DRIVE_IN_WRITE: assert property (mem_doe_o |-> !mem_cs_n_o && mem_oe_n_o)
    else $error("data driven outside a write");
  AST_NARROW_LANE: assert property (!mem_wide_o |-> mem_uwe_n_o)
    else $error("upper strobe on 8-bit path");
  AST_CS_NEEDS_REQ: assert property (!mem_cs_n_o |-> cpu_req_i)
    else $error("chip-select without access");
  AST_REFUSE_NO_CYCLE: assert property (cpu_berr_o |-> mem_cs_n_o && $past(mem_cs_n_o))
    else $error("memory cycle on refused access");
  AST_ONE_ANSWER: assert property (cpu_ack_o || cpu_berr_o |->
    !(cpu_ack_o && cpu_berr_o) ##1 !(cpu_ack_o || cpu_berr_o))
    else $error("processor answer malformed");
  cover property (cpu_berr_o);
  cover property ($fell(mem_lwe_n_o) && !$fell(mem_cs_n_o));
  cover property (!mem_wide_o && !mem_lwe_n_o);
endmodule

bind csb_region csb_region_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .cpu_req_i, .cpu_ack_o, .cpu_berr_o, .mem_cs_n_o, .mem_oe_n_o, .mem_doe_o,
  .mem_lwe_n_o, .mem_uwe_n_o,
  .mem_wide_o, .irq_o);

// file: csb_mem_model.sv
// behavioural memory on the chip-select b region pins
`timescale 1ns/1ns

module csb_mem_model
(
  // clock
  input  wire        clk_i,
  // strobes from the region
  input  wire        cs_n_i,
  input  wire        oe_n_i,
  input  wire        lwe_n_i,
  input  wire        uwe_n_i,
  input  wire        wide_i,
  // address and data
  input  wire [7:0]  addr_i,
  input  wire [15:0] dout_i,
  output wire [15:0] din_o,
  output wire        ext_ack_n_o
);
  reg  [7:0]  mem [0:255];
  reg  [15:0] last = 16'h5a5a;
  reg  [2:0]  cnt = 3'h0;
  wire [7:0]  ev = {addr_i[7:1], 1'b0};
  wire [7:0]  od = {addr_i[7:1], 1'b1};
  wire        rd = !cs_n_i && !oe_n_i;
  always @(posedge clk_i)
  begin
    if (!cs_n_i && !lwe_n_i)
      mem[wide_i ? od : addr_i] <= dout_i[7:0];
    if (!cs_n_i && !uwe_n_i && wide_i)
      mem[ev] <= dout_i[15:8];
    if (rd)
      last <= din_o;
    cnt <= cs_n_i ? 3'h0 : (cnt == 3'h7 ? cnt : cnt + 3'h1);
  end
  // narrow reads on low lane; idle bus shows the inverse, not stale data
  assign din_o = !rd ? ~last : wide_i ? {mem[ev], mem[od]} : {~last[15:8], mem[addr_i]};
  assign ext_ack_n_o = !(cnt >= 3'h3);
endmodule

// file: csb_region_tb.sv
// self-checking bench of the chip-select b region block
`timescale 1ns/1ns
`include "csb_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end

module csb_region_tb;
  localparam [4:0] CFG = `CSB_OFS_CONFIG, CTL = `CSB_OFS_CONTROL, STA = `CSB_OFS_STATUS;
  localparam [4:0] MSK = `CSB_OFS_MASK, BAS = `CSB_OFS_BASE;
  // ****
  // stimulus and wiring
  // ****
  reg         clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg  [4:2]  wb_adr_i = 3'h0;
  reg  [3:0]  wb_sel_i = 4'hf;
  reg  [31:0] wb_dat_i = 32'h0, rd;
  reg         cpu_req_i = 1'b0, cpu_we_i = 1'b0, cpu_super_i = 1'b0, berr;
  reg  [23:0] cpu_addr_i = 24'h0;
  reg  [1:0]  cpu_sel_i = 2'h3;
  reg  [15:0] cpu_wdata_i = 16'h0, rdat;
  wire [31:0] wb_dat_o;
  wire [15:0] cpu_rdata_o, mem_dout_o, mem_din_i;
  wire [23:0] mem_addr_o;
  wire        wb_ack_o, cpu_ack_o, cpu_berr_o, mem_cs_n_o, mem_oe_n_o, mem_lwe_n_o;
  wire        mem_uwe_n_o, mem_wide_o, mem_ext_ack_n_i, irq_o;
  integer     failures = 0, checks_done = 0, cycles = 0, n, cs_at, we_at, i;
  always #2 clk_i = ~clk_i;
  csb_region dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_req_i, .cpu_addr_i, .cpu_we_i, .cpu_super_i,
    .cpu_sel_i, .cpu_wdata_i, .cpu_rdata_o, .cpu_ack_o, .cpu_berr_o, .mem_cs_n_o,
    .mem_oe_n_o, .mem_lwe_n_o, .mem_uwe_n_o, .mem_addr_o, .mem_dout_o, .mem_doe_o(),
    .mem_wide_o, .mem_din_i, .mem_ext_ack_n_i, .irq_o);
  csb_mem_model mem (.clk_i, .cs_n_i(mem_cs_n_o), .oe_n_i(mem_oe_n_o), .lwe_n_i(mem_lwe_n_o),
    .uwe_n_i(mem_uwe_n_o), .wide_i(mem_wide_o), .addr_i(mem_addr_o[7:0]),
    .dout_i(mem_dout_o), .din_o(mem_din_i), .ext_ack_n_o(mem_ext_ack_n_i));
  // ****
  // access tasks
  // ****
  task automatic wrap_up;
    begin
      if (failures == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task automatic wb(input reg we, input reg [4:0] o, input reg [31:0] d);
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= o[4:2];
      wb_dat_i <= d;
      do
        @(posedge clk_i);
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task automatic wr(input reg [4:0] o, input reg [31:0] d);
    wb(1'b1, o, d);
  endtask
  task automatic rdc(input reg [4:0] o, input reg [31:0] e);
    begin
      wb(1'b0, o, 32'h0);
      `CHK(rd, e)
    end
  endtask
  // ws = {write, supervisor}; en below zero skips the cycle count
  task automatic acc(input reg [1:0] ws, input reg [23:0] a, input reg [15:0] d,
                     input integer en, input reg eb);
    begin
      n = 0;
      cs_at = 0;
      we_at = 0;
      cpu_req_i <= 1'b1;
      {cpu_we_i, cpu_super_i} <= ws;
      cpu_addr_i <= a;
      cpu_wdata_i <= d;
      do
      begin
        @(posedge clk_i);
        n = n + 1;
        if (mem_cs_n_o === 1'b0 && cs_at == 0)
          cs_at = n;
        if ((mem_lwe_n_o & mem_uwe_n_o) === 1'b0 && we_at == 0)
          we_at = n;
      end
      while (cpu_ack_o !== 1'b1 && cpu_berr_o !== 1'b1 && n < 40);
      berr = cpu_berr_o;
      rdat = cpu_rdata_o;
      cpu_req_i <= 1'b0;
      @(posedge clk_i);
      if (en >= 0)
        `CHK(n, en)
      `CHK(berr, eb)
    end
  endtask
  function automatic [31:0] cfg(input reg [2:0] p, input reg [1:0] u, f, input reg [2:0] w);
    cfg = {16'h0, p, u, 2'b00, f, w, 3'h2, 1'b1};
  endfunction
  // ****
  // scenarios
  // ****
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(CFG, 32'h0);
    rdc(CTL, 32'h0);
    rdc(BAS, 32'h0);
    rdc(STA, 32'h0);
    rdc(MSK, 32'h0);
    rdc(5'h14, 32'h0);
    wr(CFG, 32'hf9ff);
    rdc(CFG, 32'hf9fe);
    wr(CFG, 32'h0080);
    acc(2'h1, 24'h10, 16'h0, 40, 1'b0);
    `CHK(cs_at, 0)
    wr(CTL, 32'h1);
    wr(CFG, cfg(3'h0, 2'h0, 2'h1, 3'h0));
    acc(2'h3, 24'h10, 16'hbeef, 3, 1'b0);
    `CHK(we_at, cs_at)
    acc(2'h1, 24'h10, 16'h0, 3, 1'b0);
    `CHK(rdat, 16'hbeef)
    acc(2'h1, 24'h7fffe, 16'h0, 3, 1'b0);
    acc(2'h1, 24'h80000, 16'h0, 40, 1'b0);
    `CHK(cs_at, 0)
    // moved base: only the window above it answers
    wr(BAS, 32'h80000);
    rdc(BAS, 32'h80000);
    acc(2'h1, 24'h80010, 16'h0, 3, 1'b0);
    `CHK(rdat, 16'hbeef)
    acc(2'h1, 24'h10, 16'h0, 40, 1'b0);
    wr(BAS, 32'h0);
    for (i = 0; i < 7; i = i + 1)
    begin
      wr(CFG, cfg(3'h0, 2'h0, 2'h1, i[2:0]));
      acc(2'h1, 24'h10, 16'h0, 3 + 2 * i, 1'b0);
    end
    wr(CTL, 32'h3);
    acc(2'h1, 24'h10, 16'h0, 16, 1'b0);
    wr(CFG, cfg(3'h0, 2'h0, 2'h1, 3'h7));
    // model acknowledges after three selected cycles
    acc(2'h1, 24'h10, 16'h0, 6, 1'b0);
    `CHK(rdat, 16'hbeef)
    wr(CTL, 32'h1);
    wr(CFG, cfg(3'h0, 2'h0, 2'h3, 3'h0));
    acc(2'h3, 24'h12, 16'h5a5a, 4, 1'b0);
    `CHK(we_at, cs_at + 1)
    wr(CFG, cfg(3'h0, 2'h0, 2'h0, 3'h0));
    acc(2'h3, 24'h20, 16'h1234, 5, 1'b0);
    acc(2'h1, 24'h20, 16'h0, 5, 1'b0);
    `CHK(rdat, 16'h1234)
    wr(CFG, cfg(3'h4, 2'h0, 2'h1, 3'h0));
    acc(2'h1, 24'h20, 16'h0, 3, 1'b0);
    `CHK(rdat, 16'h1234)
    acc(2'h3, 24'h10, 16'h0, 2, 1'b1);
    `CHK(irq_o, 1'b0)
    wr(MSK, 32'h7);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    rdc(STA, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wr(CTL, 32'h0);
    acc(2'h3, 24'h10, 16'h0, 2, 1'b0);
    acc(2'h1, 24'h10, 16'h0, 3, 1'b0);
    `CHK(rdat, 16'hbeef)
    rdc(STA, 32'h1);
    wr(CTL, 32'h1);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(CFG, cfg(3'h2, i[1:0], 2'h1, 3'h0));
      acc(2'h0, (24'h8000 << i) - 24'h2, 16'h0, 3, 1'b0);
      acc(2'h0, 24'h8000 << i, 16'h0, 2, 1'b1);
    end
    acc(2'h1, 24'h40000, 16'h0, 3, 1'b0);
    rdc(STA, 32'h2);
    wr(CFG, cfg(3'h1, 2'h0, 2'h1, 3'h0));
    wr(CTL, 32'h0);
    acc(2'h3, 24'h8000, 16'h0, 2, 1'b1);
    rdc(STA, 32'h4);
    acc(2'h3, 24'h7ffe, 16'h1111, 3, 1'b0);
    // lower byte alone on the 16-bit path
    cpu_sel_i <= 2'h1;
    acc(2'h3, 24'h10, 16'h00aa, 3, 1'b0);
    cpu_sel_i <= 2'h3;
    acc(2'h1, 24'h10, 16'h0, 3, 1'b0);
    `CHK(rdat, 16'hbeaa)
    wrap_up;
  end
  // hang guard, well above the few hundred cycles needed
  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      wrap_up;
    end
  end
endmodule
